//--- core/pmu_wake_params.svh
/*
  Constants for the power-management wake and command register bank: offsets, field positions, reset values and timing.
  Assumes inclusion by bare name from the main module.
*/
`ifndef PMU_WAKE_PARAMS_SVH
`define PMU_WAKE_PARAMS_SVH
// Printed offsets are register indices; byte address is four times the index
`define IDX_CORE_DRIVE 8'h24
`define IDX_CORE_ZC 8'h25
`define IDX_ANA_LIMIT 8'h26
`define IDX_ANA_DRIVE 8'h27
`define IDX_ANA_ZC 8'h28
`define IDX_LDO_DIS 8'h29
`define IDX_WAKE_STAT 8'h30
`define IDX_WAKE_STAT_CLR 8'h31
`define IDX_WAKE_TRG 8'h32
`define IDX_WAKE_TRG_CLR 8'h33
`define IDX_IRQ_CAUSE 8'h34
`define IDX_IRQ_CAUSE_CLR 8'h35
`define IDX_CORE_SAVED 8'h36
`define IDX_POWER_CMD 8'h37
`define IDX_WAKE_PIN_CFG 8'h38
// Reset values
`define RST_DRIVE 8'h2a
`define RST_ZC 2'h2
`define RST_ANA_LIMIT 8'h0a
`define RST_LDO_DIS 8'h00
`define RST_CORE_SAVED 6'h24
`define RST_POWER_CMD 7'h06
// Power command bit positions
`define CMD_SLEEP 0
`define CMD_ALARM_EN 1
`define CMD_PIN_EN 2
`define CMD_WAKE 3
`define CMD_SYSRST 4
`define CMD_WD_KICK 5
`define CMD_WD_EN 6
// Wake reason codes
`define WR_NORMAL 3'h0
`define WR_SHORT_PIN 3'h1
`define WR_LONG_PIN 3'h2
`define WR_WAKE_CMD 3'h4
`define WR_AUTO 3'h5
// Long pin hold time
`define LONG_HOLD_MS 3000
`define CLK_MHZ 100
`endif

//--- core/pmu_wake_pkg.sv
/*
  Types for the power-management wake and command register bank.
  Assumes the params header is on the include path.
*/
package pmu_wake_pkg;
  typedef enum logic [2:0] {
    st_ready,
    st_startup,
    st_power_on,
    st_deep_sleep
  } power_state_t;
  typedef logic [7:0] reg_byte_t;
endpackage

//--- core/pmu_hold_timer.sv
/*
  Counts how long the long wake pin has been held (pin_low high) and pulses once when the hold time is reached.
  Assumes the pin is synchronous to pclk; hold count is a parameter so simulation can shorten it.
*/
`timescale 1ns/100ps
module pmu_hold_timer #(
  parameter int unsigned HOLD_CYCLES = 300000000
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Pin and result
  input wire logic pin_low,
  output logic held_pulse
);
  logic [31:0] count_q;
  logic done_q;

  // Count while held, fire once per press
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= 32'h0000_0000;
      done_q <= 1'b0;
      held_pulse <= 1'b0;
    end else if (clk_en) begin
      held_pulse <= 1'b0;
      if (!pin_low) begin
        count_q <= 32'h0000_0000;
        done_q <= 1'b0;
      end else if (!done_q) begin
        if (count_q == HOLD_CYCLES - 1) begin
          held_pulse <= 1'b1;
          done_q <= 1'b1;
        end else begin
          count_q <= count_q + 32'h0000_0001;
        end
      end
    end
  end
endmodule

//--- core/pmu_wake_cmd_regs.sv
/*
  Power-management wake/command register bank with APB slave, converter tuning fields, wake status,
  trigger and interrupt-cause latches, command bits and a small power state sequencer.
  Assumes an APB master on pclk; event inputs are synchronous one-cycle pulses or levels from the device.
*/
`timescale 1ns/100ps
`include "pmu_wake_params.svh"
module pmu_wake_cmd_regs #(
  parameter int unsigned HOLD_CYCLES = `LONG_HOLD_MS * 1000 * `CLK_MHZ
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Wake events, active high pulses or held levels, and the live core voltage code
  input wire logic short_wake_pin,
  input wire logic long_wake_pin,
  input wire logic alarm_evt,
  input wire logic lowvolt_prewarn,
  input wire logic usb_good_evt,
  input wire logic usb_dead_evt,
  input wire logic watchdog_timer,
  input wire logic [5:0] core_code_now,
  // Converter settings
  output pmu_wake_pkg::reg_byte_t core_drive,
  output logic [1:0] core_zero_cross_thresh,
  output pmu_wake_pkg::reg_byte_t analog_drive,
  output logic [1:0] analog_zero_cross_thresh,
  output logic [5:0] analog_limits,
  output pmu_wake_pkg::reg_byte_t ldo_discharge,
  // Power control
  output pmu_wake_pkg::power_state_t power_state,
  output logic watchdog_en,
  output logic watchdog_kick
);
  import pmu_wake_pkg::*;

  logic [7:0] core_drive_q, analog_drive_q, analog_limit_q, ldo_q;
  logic [1:0] core_zc_q, analog_zc_q;
  logic lowvolt_wake_flag_q;
  logic [1:0] usb_wake_cause_q, reset_wake_cause_q;
  logic [2:0] normal_wake_cause_q;
  logic [6:0] trg_q;
  logic [3:0] irq_q;
  logic [5:0] saved_core_code_q;
  logic [6:0] cmd_q;
  logic long_pin_transition_en_q;
  power_state_t state_q, state_d;
  logic long_held;
  logic wr_en, rd_en;
  logic [7:0] idx;
  logic [7:0] wdat;
  logic mapped;
  logic enter_startup, enter_ready, enter_power_on;
  logic [2:0] reason_d;

  // Word index decode; APB answers in the access phase with no wait states
  function automatic logic is_mapped(input logic [7:0] i);
    return (i >= `IDX_CORE_DRIVE && i <= `IDX_LDO_DIS) || (i >= `IDX_WAKE_STAT && i <= `IDX_WAKE_PIN_CFG);
  endfunction

  assign idx = paddr[9:2];
  assign mapped = is_mapped(idx) && (paddr[11:10] == 2'b00);
  assign wdat = pstrb[0] ? pwdata[7:0] : 8'h00;
  assign wr_en = clk_en && psel && penable && pwrite && mapped && pstrb[0];
  assign rd_en = clk_en && psel && penable && !pwrite;

  // Long pin hold detector
  pmu_hold_timer #(.HOLD_CYCLES(HOLD_CYCLES)) u_hold (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .pin_low(long_wake_pin),
    .held_pulse(long_held)
  );

  // Power state sequencer: ready -> startup -> power-on, sleep and wake between
  always_comb begin
    state_d = state_q;
    reason_d = `WR_NORMAL;
    unique case (state_q)
      st_ready: state_d = st_startup;
      st_startup: state_d = st_power_on;
      st_power_on: begin
        if (cmd_q[`CMD_SYSRST] || watchdog_timer) begin
          state_d = st_ready;
        end else if (cmd_q[`CMD_SLEEP]) begin
          state_d = st_deep_sleep;
        end else if (long_held && long_pin_transition_en_q) begin
          state_d = st_deep_sleep;
        end
      end
      st_deep_sleep: begin
        if (cmd_q[2:0] == 3'b001) begin
          state_d = st_startup;
          reason_d = `WR_AUTO;
        end else if (cmd_q[`CMD_WAKE]) begin
          state_d = st_startup;
          reason_d = `WR_WAKE_CMD;
        end else if (long_held && long_pin_transition_en_q) begin
          state_d = st_startup;
          reason_d = `WR_LONG_PIN;
        end else if (short_wake_pin && cmd_q[`CMD_PIN_EN]) begin
          state_d = st_startup;
          reason_d = `WR_SHORT_PIN;
        end else if (alarm_evt && cmd_q[`CMD_ALARM_EN]) begin
          state_d = st_startup;
        end else if (lowvolt_prewarn || usb_good_evt) begin
          state_d = st_startup;
        end
      end
      default: state_d = st_ready;
    endcase
  end

  assign enter_startup = (state_d == st_startup) && (state_q != st_startup);
  assign enter_ready = (state_d == st_ready) && (state_q != st_ready);
  assign enter_power_on = (state_d == st_power_on) && (state_q != st_power_on);

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= st_ready;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  // Converter and regulator settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_drive_q <= `RST_DRIVE;
      analog_drive_q <= `RST_DRIVE;
      core_zc_q <= `RST_ZC;
      analog_zc_q <= `RST_ZC;
      analog_limit_q <= `RST_ANA_LIMIT;
      ldo_q <= `RST_LDO_DIS;
    end else if (wr_en) begin
      if (idx == `IDX_CORE_DRIVE) core_drive_q <= wdat;
      if (idx == `IDX_ANA_DRIVE) analog_drive_q <= wdat;
      if (idx == `IDX_CORE_ZC) core_zc_q <= wdat[1:0];
      if (idx == `IDX_ANA_ZC) analog_zc_q <= wdat[1:0];
      if (idx == `IDX_ANA_LIMIT) analog_limit_q <= {2'b00, wdat[5:0]};
      if (idx == `IDX_LDO_DIS) ldo_q <= wdat;
    end
  end

  // Wake status fields; a new cause wins over a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lowvolt_wake_flag_q <= 1'b0;
      usb_wake_cause_q <= 2'b00;
      reset_wake_cause_q <= 2'b00;
      normal_wake_cause_q <= `WR_NORMAL;
    end else if (clk_en) begin
      if (wr_en && idx == `IDX_WAKE_STAT_CLR) begin
        if (wdat[0]) normal_wake_cause_q <= `WR_NORMAL;
        if (wdat[1]) reset_wake_cause_q <= 2'b00;
        if (wdat[2]) usb_wake_cause_q <= 2'b00;
        if (wdat[3]) lowvolt_wake_flag_q <= 1'b0;
      end
      if (enter_startup && state_q == st_deep_sleep) begin
        if (reason_d != `WR_NORMAL) normal_wake_cause_q <= reason_d;
        if (lowvolt_prewarn) lowvolt_wake_flag_q <= 1'b1;
        if (usb_good_evt) usb_wake_cause_q <= 2'b01;
      end
      if (usb_dead_evt) usb_wake_cause_q <= 2'b10;
      if (enter_ready) reset_wake_cause_q <= watchdog_timer ? 2'b10 : 2'b01;
    end
  end

  // Trigger latch and interrupt cause latch; set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trg_q <= 7'h00;
      irq_q <= 4'h0;
    end else if (clk_en) begin
      trg_q <= (trg_q & ~((wr_en && idx == `IDX_WAKE_TRG_CLR) ? wdat[6:0] : 7'h00))
        | {lowvolt_prewarn, usb_dead_evt, usb_good_evt, cmd_q[`CMD_WAKE],
           alarm_evt, long_held, short_wake_pin};
      irq_q <= (irq_q & ~((wr_en && idx == `IDX_IRQ_CAUSE_CLR) ? wdat[3:0] : 4'h0))
        | {lowvolt_prewarn, long_held, short_wake_pin, alarm_evt};
    end
  end

  // Saved core voltage code, captured on a watchdog timeout while the watchdog enable bit is set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      saved_core_code_q <= `RST_CORE_SAVED;
    end else if (clk_en && watchdog_timer && cmd_q[`CMD_WD_EN]) begin
      saved_core_code_q <= core_code_now;
    end
  end

  // Command bits with hardware clears; the state event wins over a write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q <= `RST_POWER_CMD;
      long_pin_transition_en_q <= 1'b0;
    end else if (clk_en) begin
      if (wr_en && idx == `IDX_POWER_CMD) cmd_q <= wdat[6:0];
      if (wr_en && idx == `IDX_WAKE_PIN_CFG) long_pin_transition_en_q <= wdat[1];
      if (enter_startup) begin
        cmd_q[`CMD_SLEEP] <= 1'b0;
        cmd_q[`CMD_WAKE] <= 1'b0;
      end
      if (enter_ready) cmd_q[`CMD_SYSRST] <= 1'b0;
      if (watchdog_timer || (wr_en && idx == `IDX_WAKE_TRG_CLR && wdat[6:0] != 7'h00)) begin
        cmd_q[`CMD_WD_KICK] <= 1'b0;
      end
    end
  end

  // Read data and response, registered; clear registers read back zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !(is_mapped(paddr[9:2]) && paddr[11:10] == 2'b00);
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        unique case (paddr[9:2])
          `IDX_CORE_DRIVE: prdata[7:0] <= core_drive_q;
          `IDX_CORE_ZC: prdata[1:0] <= core_zc_q;
          `IDX_ANA_LIMIT: prdata[7:0] <= analog_limit_q;
          `IDX_ANA_DRIVE: prdata[7:0] <= analog_drive_q;
          `IDX_ANA_ZC: prdata[1:0] <= analog_zc_q;
          `IDX_LDO_DIS: prdata[7:0] <= ldo_q;
          `IDX_WAKE_STAT: prdata[7:0] <= {lowvolt_wake_flag_q, usb_wake_cause_q,
                                          reset_wake_cause_q, normal_wake_cause_q};
          `IDX_WAKE_TRG: prdata[6:0] <= trg_q;
          `IDX_IRQ_CAUSE: prdata[3:0] <= irq_q;
          `IDX_CORE_SAVED: prdata[5:0] <= saved_core_code_q;
          `IDX_POWER_CMD: prdata[6:0] <= cmd_q;
          `IDX_WAKE_PIN_CFG: prdata[1] <= long_pin_transition_en_q;
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Registered outputs toward the converters and sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_drive <= `RST_DRIVE;
      analog_drive <= `RST_DRIVE;
      core_zero_cross_thresh <= 2'b10;
      analog_zero_cross_thresh <= 2'b10;
      analog_limits <= 6'h0a;
      ldo_discharge <= `RST_LDO_DIS;
      power_state <= st_ready;
      watchdog_en <= 1'b0;
      watchdog_kick <= 1'b0;
    end else if (clk_en) begin
      core_drive <= core_drive_q;
      analog_drive <= analog_drive_q;
      core_zero_cross_thresh <= core_zc_q;
      analog_zero_cross_thresh <= analog_zc_q;
      analog_limits <= analog_limit_q[5:0];
      ldo_discharge <= ldo_q;
      power_state <= state_q;
      watchdog_en <= cmd_q[`CMD_WD_EN];
      watchdog_kick <= cmd_q[`CMD_WD_KICK];
    end
  end

  // Checks
  a_sleep_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && enter_startup) |=> !cmd_q[`CMD_SLEEP]) else $error("sleep bit not cleared");
  a_wake_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && enter_startup) |=> !cmd_q[`CMD_WAKE]) else $error("wake bit not cleared");
  a_sysrst_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && enter_ready) |=> !cmd_q[`CMD_SYSRST]) else $error("sysreset bit not cleared");
  a_auto_wake: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && state_q == st_deep_sleep && cmd_q[2:0] == 3'b001) |=> state_q == st_startup)
    else $error("no automatic wake");
  a_trg_latch: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && alarm_evt) |=> trg_q[2]) else $error("alarm trigger lost");
  a_irq_latch: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && lowvolt_prewarn) |=> irq_q[3]) else $error("lowvolt cause lost");
  a_trg_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && idx == `IDX_WAKE_TRG_CLR && wdat[0] && !short_wake_pin) |=> !trg_q[0])
    else $error("trigger not cleared");
  a_irq_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && idx == `IDX_IRQ_CAUSE_CLR && wdat[0] && !alarm_evt) |=> !irq_q[0])
    else $error("cause not cleared");
  a_long_pin_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && state_q == st_deep_sleep && long_held && long_pin_transition_en_q) |=> state_q == st_startup)
    else $error("long pin wake missed");
  a_wd_kick_clr: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && watchdog_timer) |=> !cmd_q[`CMD_WD_KICK]) else $error("kick bit not cleared");
endmodule

//--- test/pmu_host_model.sv
/*
  Host-side APB master model that programs the wake and command register bank.
  Assumes a single clock pclk; the bench calls xfer hierarchically after a rising edge.
*/
`timescale 1ns/100ps
module pmu_host_model (
  // Clock
  input wire logic pclk,
  // Request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  // Answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
  end

  // Setup, then access held until pready is sampled high or 50 further edges have passed; a spare edge keeps drivers apart
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [3:0] st,
                      output logic [31:0] rd, output logic err, output logic to);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    rd = prdata;
    err = pslverr;
    to = (n >= 50);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
endmodule

//--- test/test_pmu_wake_cmd_regs.sv
/*
  Self-checking bench for the wake and command register bank: defaults, readback, latches, commands, sequencer.
  Assumes the host model drives APB and that the hold count is shortened to HOLD cycles.
*/
`timescale 1ns/100ps
module test_pmu_wake_cmd_regs;
  import pmu_wake_pkg::*;
  localparam int unsigned HOLD = 20;
  localparam logic [11:0] ADDRS [15] = '{12'h090, 12'h094, 12'h098, 12'h09C, 12'h0A0, 12'h0A4, 12'h0C0,
    12'h0C4, 12'h0C8, 12'h0CC, 12'h0D0, 12'h0D4, 12'h0D8, 12'h0DC, 12'h0E0};
  localparam logic [7:0] DEFS [15] = '{8'h2a, 8'h02, 8'h0a, 8'h2a, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h24, 8'h06, 8'h00};
  localparam int RW_IDX [7] = '{0, 1, 2, 3, 4, 5, 14};
  localparam logic [7:0] RW_MASK [7] = '{8'hff, 8'h03, 8'h3f, 8'hff, 8'h03, 8'hff, 8'h02};
  localparam int TRG_BIT [5] = '{0, 2, 6, 4, 5};
  localparam logic [7:0] IRQ_MASK [5] = '{8'h02, 8'h01, 8'h08, 8'h00, 8'h00};
  logic pclk, presetn, clk_en;
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [4:0] evt; // Short pin, alarm, low voltage, usb good, usb dead
  logic long_pin, wdog;
  logic [5:0] code_now, ana_lim;
  logic [1:0] core_zc, ana_zc;
  reg_byte_t core_drive, analog_drive, dis_sel;
  power_state_t pstate;
  logic wd_en, wd_kick;
  logic [7:0] vals [7];
  logic [31:0] rd;
  logic err;
  int n_errors = 0;
  int checks = 0;

  pmu_wake_cmd_regs #(.HOLD_CYCLES(HOLD)) DUT (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .short_wake_pin(evt[0]), .long_wake_pin(long_pin),
    .alarm_evt(evt[1]), .lowvolt_prewarn(evt[2]), .usb_good_evt(evt[3]), .usb_dead_evt(evt[4]),
    .watchdog_timer(wdog), .core_code_now(code_now), .core_drive(core_drive),
    .core_zero_cross_thresh(core_zc), .analog_drive(analog_drive), .analog_zero_cross_thresh(ana_zc),
    .analog_limits(ana_lim), .ldo_discharge(dis_sel), .power_state(pstate), .watchdog_en(wd_en),
    .watchdog_kick(wd_kick));

  pmu_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // Free running 100 MHz clock
  initial pclk = 1'b0;
  always #5 pclk = ~pclk;

  // Verdict and end of run
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Value comparison
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One bus transfer; a hung slave ends the run
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [3:0] st);
    logic to;
    host.xfer(w, a, 32'(d), st, rd, err, to);
    if (to) begin
      n_errors++;
      $display("ERROR pready expected 1 seen 0");
      stop_test();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask

  // Register read comparison
  task automatic chk(input string what, input logic [11:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00, 4'h0);
    cmp(what, 32'(exp), rd);
  endtask

  // Sequencer state comparison with a bounded wait
  task automatic wait_state(input string what, input power_state_t s);
    int n;
    n = 0;
    while (pstate !== s && n < 200) begin
      @(posedge pclk);
      n++;
    end
    cmp(what, 32'(s), 32'(pstate));
    if (n >= 200) stop_test();
  endtask

  task automatic pulse(input int i);
    evt[i] <= 1'b1;
    @(posedge pclk);
    evt[i] <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic clr_all();
    wr(12'h0C4, 8'h0f);
    wr(12'h0CC, 8'h7f);
    wr(12'h0D4, 8'h0f);
  endtask

  task automatic reset_and_defaults();
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 15; i++) chk("reset value", ADDRS[i], DEFS[i]);
    cmp("drive port", 32'h0000_002a, 32'(core_drive));
    cmp("limit port", 32'h0000_000a, 32'(ana_lim));
    wait_state("state after reset", st_power_on);
    $display("Test reset defaults done");
  endtask

  // Main sequence
  initial begin
    presetn = 1'b0;
    clk_en = 1'b1;
    evt = 5'h00;
    long_pin = 1'b0;
    wdog = 1'b0;
    code_now = 6'h00;
    void'($urandom(32'ha0ad_cea0));
    @(posedge pclk);
    reset_and_defaults();
    // Random readback of writable settings, then the copies at the ports
    for (int k = 0; k < 28; k++) begin
      int i;
      logic [7:0] d;
      i = k % 7;
      d = 8'($urandom);
      if (i == 2) d = 8'({2'($urandom), 2'($urandom_range(2)), 2'($urandom_range(2))});
      wr(ADDRS[RW_IDX[i]], d);
      vals[i] = d & RW_MASK[i];
      chk("setting readback", ADDRS[RW_IDX[i]], vals[i]);
    end
    wr(12'h0E0, 8'h00);
    cmp("core drive port", 32'(vals[0]), 32'(core_drive));
    cmp("core zc port", 32'(vals[1]), 32'(core_zc));
    cmp("limit port", 32'(vals[2]), 32'(ana_lim));
    cmp("analog drive port", 32'(vals[3]), 32'(analog_drive));
    cmp("analog zc port", 32'(vals[4]), 32'(ana_zc));
    cmp("discharge port", 32'(vals[5]), 32'(dis_sel));
    // Refused and read-only accesses
    bus(1'b0, 12'h3FC, 8'h00, 4'h0);
    cmp("unmapped error", 32'h0000_0001, 32'(err));
    cmp("unmapped data", 32'h0000_0000, rd);
    bus(1'b1, 12'h090, ~vals[0], 4'h0);
    chk("strobe off write", 12'h090, vals[0]);
    wr(12'h0D8, 8'hff);
    chk("saved code read only", 12'h0D8, 8'h24);
    wr(12'h0C8, 8'hff);
    chk("trigger read only", 12'h0C8, 8'h00);
    $display("Test settings done");
    // Each event latches, survives a zero write, clears on a one write
    for (int i = 0; i < 5; i++) begin
      pulse(i);
      chk("trigger latch", 12'h0C8, 8'(1 << TRG_BIT[i]));
      chk("irq cause", 12'h0D0, IRQ_MASK[i]);
      wr(12'h0CC, 8'h00);
      wr(12'h0D4, 8'h00);
      chk("trigger kept", 12'h0C8, 8'(1 << TRG_BIT[i]));
      wr(12'h0CC, 8'(1 << TRG_BIT[i]));
      wr(12'h0D4, IRQ_MASK[i]);
      chk("trigger cleared", 12'h0C8, 8'h00);
      chk("irq cleared", 12'h0D0, 8'h00);
      chk("clear reads zero", 12'h0CC, 8'h00);
    end
    wr(12'h0C4, 8'h0f);
    chk("status cleared", 12'h0C0, 8'h00);
    chk("status clear self", 12'h0C4, 8'h00);
    $display("Test latches done");
    // Automatic return with sleep bits 001
    wr(12'h0DC, 8'h01);
    wait_state("auto sleep", st_deep_sleep);
    wait_state("auto return", st_power_on);
    chk("sleep bit cleared", 12'h0DC, 8'h00);
    chk("auto reason", 12'h0C0, 8'h05);
    clr_all();
    // Wake command
    wr(12'h0DC, 8'h07);
    wait_state("sleep", st_deep_sleep);
    wr(12'h0DC, 8'h0e);
    wait_state("command wake", st_power_on);
    chk("wake bit cleared", 12'h0DC, 8'h06);
    chk("command reason", 12'h0C0, 8'h04);
    chk("command trigger", 12'h0C8, 8'h08);
    clr_all();
    // Alarm wake disabled, then short pin wake
    wr(12'h0DC, 8'h05);
    wait_state("sleep", st_deep_sleep);
    pulse(1);
    repeat (5) @(posedge pclk);
    cmp("alarm ignored", 32'(st_deep_sleep), 32'(pstate));
    pulse(0);
    wait_state("pin wake", st_power_on);
    chk("pin reason", 12'h0C0, 8'h01);
    clr_all();
    wr(12'h0DC, 8'h06);
    // System reset command
    wr(12'h0DC, 8'h16);
    wait_state("reset entry", st_ready);
    wait_state("reset exit", st_power_on);
    chk("reset bit cleared", 12'h0DC, 8'h06);
    chk("reset cause", 12'h0C0, 8'h08);
    clr_all();
    $display("Test commands done");
    // Watchdog enable, kick, capture and kick clears
    code_now <= 6'($urandom);
    wr(12'h0DC, 8'h66);
    @(posedge pclk);
    cmp("watchdog enable", 32'h0000_0001, 32'(wd_en));
    cmp("watchdog kick", 32'h0000_0001, 32'(wd_kick));
    wdog <= 1'b1;
    @(posedge pclk);
    wdog <= 1'b0;
    wait_state("watchdog entry", st_ready);
    wait_state("watchdog exit", st_power_on);
    cmp("kick after watchdog", 32'h0000_0000, 32'(wd_kick));
    chk("saved code", 12'h0D8, 8'(code_now));
    chk("watchdog cause", 12'h0C0, 8'h10);
    clr_all();
    wr(12'h0DC, 8'h26);
    wr(12'h0CC, 8'h01);
    @(posedge pclk);
    cmp("kick after trigger clear", 32'h0000_0000, 32'(wd_kick));
    wr(12'h0DC, 8'h06);
    $display("Test watchdog done");
    // Long pin ignored while disabled, then sleep and wake after the hold time
    long_pin <= 1'b1;
    repeat (HOLD + 10) @(posedge pclk);
    cmp("long pin disabled", 32'(st_power_on), 32'(pstate));
    long_pin <= 1'b0;
    wr(12'h0E0, 8'h02);
    long_pin <= 1'b1;
    repeat (HOLD - 3) @(posedge pclk);
    cmp("hold not yet", 32'(st_power_on), 32'(pstate));
    wait_state("long pin sleep", st_deep_sleep);
    long_pin <= 1'b0;
    repeat (4) @(posedge pclk);
    long_pin <= 1'b1;
    wait_state("long pin wake", st_power_on);
    long_pin <= 1'b0;
    chk("long pin reason", 12'h0C0, 8'h02);
    $display("Test long pin done");
    reset_and_defaults();
    stop_test();
  end
endmodule
